//--- dual_slope_pwm_timer.sv
// dual-slope pwm timer: apb registers, up/down counter, buffered compares, flags
// assumes a single pclk domain and an apb master that holds requests until pready
//
// Added by the designer: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module dual_slope_pwm_timer
	import pwm_timer_pkg::*;
#(
	parameter int NCH = NUM_CH
)
(
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic         ce,
	input  wire apb_req_t     apb_req,
	output logic [31:0]       prdata,
	output logic              pready,
	output logic              pslverr,
	output logic [NCH-1:0]    compare_output,
	output logic [NCH-1:0]    compare_output_oe,
	output flags_t            flags
);
	typedef enum logic [1:0] {
		SLOPE_OFF  = 2'b00,
		SLOPE_UP   = 2'b01,
		SLOPE_DOWN = 2'b10
	} slope_t;

	logic [3:0]       waveform_mode_sel;
	logic [2:0]       clock_sel_reg;
	logic [1:0]       output_action_sel [NCH];
	logic [NCH-1:0]   pin_direction_bit;
	logic [15:0]      count_value;
	logic [15:0]      compare_value_reg [NCH];
	logic [15:0]      compare_active_reg [NCH];
	logic [15:0]      capture_top_reg;
	logic [NCH-1:0]   out_level_reg;
	flags_t           flags_reg;
	slope_t           slope_reg;
	logic [31:0]      prdata_reg;
	logic             timer_tick_enable;
	logic             wr_en;
	logic             rd_setup;
	logic             addr_ok;
	logic [15:0]      top_value;
	logic             dual_mode;
	logic             pfc_mode;
	logic             at_top;
	logic             at_bottom;
	logic             buffer_load;
	flags_t           flag_set;
	flags_t           flag_clr;

	// fixed top for the 8/9/10-bit phase correct modes, zero otherwise
	function automatic logic [15:0] fixed_top(input logic [3:0] mode);
		case (mode)
			MODE_PC8:  fixed_top = TOP_8BIT;
			MODE_PC9:  fixed_top = TOP_9BIT;
			MODE_PC10: fixed_top = TOP_10BIT;
			default:   fixed_top = 16'h0000;
		endcase
	endfunction

	function automatic logic is_pfc(input logic [3:0] mode);
		is_pfc = (mode == MODE_PFC_CAP) || (mode == MODE_PFC_A);
	endfunction

	function automatic logic is_pc(input logic [3:0] mode);
		is_pc = (fixed_top(mode) != 16'h0000) || (mode == MODE_PC_CAP) || (mode == MODE_PC_A);
	endfunction

	function automatic logic top_from_capture(input logic [3:0] mode);
		top_from_capture = (mode == MODE_PFC_CAP) || (mode == MODE_PC_CAP);
	endfunction

	function automatic logic top_from_a(input logic [3:0] mode);
		top_from_a = (mode == MODE_PFC_A) || (mode == MODE_PC_A);
	endfunction

	tick_prescaler u_prescaler (
		.pclk              (pclk),
		.presetn           (presetn),
		.ce                (ce),
		.clock_sel         (clock_sel_reg),
		.timer_tick_enable (timer_tick_enable)
	);

	// mode decode and top selection
	always_comb begin
		pfc_mode  = is_pfc(waveform_mode_sel);
		dual_mode = pfc_mode || is_pc(waveform_mode_sel);
		if (top_from_capture(waveform_mode_sel))
			top_value = capture_top_reg;
		else if (top_from_a(waveform_mode_sel))
			top_value = compare_active_reg[0];
		else
			top_value = fixed_top(waveform_mode_sel);
		at_top      = (count_value == top_value);
		at_bottom   = (count_value == BOTTOM);
		// phase correct loads at top, phase-and-frequency correct at bottom
		buffer_load = timer_tick_enable && dual_mode && (pfc_mode ? at_bottom : at_top);
	end

	// apb slave: zero wait states, read data captured during setup
	assign pready   = ce;
	assign wr_en    = ce && apb_req.psel && apb_req.penable && apb_req.pwrite && addr_ok;
	assign rd_setup = ce && apb_req.psel && !apb_req.penable && !apb_req.pwrite;
	assign pslverr  = apb_req.psel && apb_req.penable && !addr_ok;
	assign prdata   = prdata_reg;

	always_comb begin
		case (apb_req.paddr)
			OFS_CTRL, OFS_OUTCFG, OFS_COUNT, OFS_CMP_A, OFS_CMP_B,
			OFS_CMP_C, OFS_CAPTOP, OFS_FLAGS, OFS_STATUS: addr_ok = 1'b1;
			default:                                      addr_ok = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= 32'h0000_0000;
		end else if (rd_setup) begin
			prdata_reg <= 32'h0000_0000;
			case (apb_req.paddr)
				OFS_CTRL:   prdata_reg <= {25'h0, clock_sel_reg, waveform_mode_sel};
				OFS_OUTCFG: prdata_reg <= {21'h0, pin_direction_bit, 2'h0, output_action_sel[2],
					output_action_sel[1], output_action_sel[0]};
				OFS_COUNT:  prdata_reg <= {16'h0, count_value};
				OFS_CMP_A:  prdata_reg <= {16'h0, compare_value_reg[0]};
				OFS_CMP_B:  prdata_reg <= {16'h0, compare_value_reg[1]};
				OFS_CMP_C:  prdata_reg <= {16'h0, compare_value_reg[2]};
				OFS_CAPTOP: prdata_reg <= {16'h0, capture_top_reg};
				OFS_FLAGS:  prdata_reg <= {27'h0, flags_reg};
				OFS_STATUS: prdata_reg <= {26'h0, slope_reg, out_level_reg, 1'b0} >> 1;
				default:    prdata_reg <= 32'h0000_0000;
			endcase
		end
	end

	// configuration registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			waveform_mode_sel <= 4'h0;
			clock_sel_reg     <= CS_STOP;
			pin_direction_bit <= '0;
			capture_top_reg   <= 16'h0000;
			for (int i = 0; i < NCH; i++)
				output_action_sel[i] <= ACT_OFF;
		end else if (wr_en) begin
			case (apb_req.paddr)
				OFS_CTRL: begin
					waveform_mode_sel <= apb_req.pwdata[CTRL_MODE_LSB +: 4];
					clock_sel_reg     <= apb_req.pwdata[CTRL_CS_LSB +: 3];
				end
				OFS_OUTCFG: begin
					for (int i = 0; i < NCH; i++)
						output_action_sel[i] <= apb_req.pwdata[2*i +: 2];
					pin_direction_bit <= apb_req.pwdata[OUTCFG_DIR_LSB +: NCH];
				end
				// capture top is unbuffered: takes effect at once
				OFS_CAPTOP: capture_top_reg <= apb_req.pwdata[15:0];
				default: begin
				end
			endcase
		end
	end

	// compare buffers and their active copies
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < NCH; i++) begin
				compare_value_reg[i]  <= 16'h0000;
				compare_active_reg[i] <= 16'h0000;
			end
		end else if (ce) begin
			for (int i = 0; i < NCH; i++) begin
				if (wr_en && apb_req.paddr == 8'(OFS_CMP_A + 8'(4*i))) begin
					if (fixed_top(waveform_mode_sel) != 16'h0000)
						compare_value_reg[i] <= apb_req.pwdata[15:0] & fixed_top(waveform_mode_sel);
					else
						compare_value_reg[i] <= apb_req.pwdata[15:0];
				end
				// outside the dual-slope modes the compare is unbuffered
				if (buffer_load || !dual_mode)
					compare_active_reg[i] <= compare_value_reg[i];
			end
		end
	end

	// up/down counter; the top value stands for exactly one tick
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_value <= BOTTOM;
			slope_reg   <= SLOPE_UP;
		end else if (ce) begin
			if (wr_en && apb_req.paddr == OFS_COUNT) begin
				count_value <= apb_req.pwdata[15:0];
			end else if (timer_tick_enable && dual_mode) begin
				case (slope_reg)
					SLOPE_UP: begin
						if (at_top) begin
							count_value <= count_value - 16'h0001;
							slope_reg   <= SLOPE_DOWN;
						end else begin
							// above top after a top change: runs on and wraps
							count_value <= count_value + 16'h0001;
						end
					end
					SLOPE_DOWN: begin
						if (at_bottom) begin
							count_value <= BOTTOM + 16'h0001;
							slope_reg   <= SLOPE_UP;
						end else begin
							count_value <= count_value - 16'h0001;
						end
					end
					default: slope_reg <= SLOPE_UP;
				endcase
			end
		end
	end

	// flag set events, all qualified by the timer tick; clears come from flag writes
	always_comb begin
		flag_set = '0;
		if (timer_tick_enable && dual_mode) begin
			flag_set.overflow_flag = at_bottom;
			// register top: its flag rises at top, with the top-time buffer load in pc mode
			flag_set.capture_flag = at_top && top_from_capture(waveform_mode_sel);
			for (int i = 0; i < NCH; i++)
				flag_set.compare_match_flag[i] = (count_value == compare_active_reg[i]);
			if (top_from_a(waveform_mode_sel) && at_top)
				flag_set.compare_match_flag[0] = 1'b1;
		end
		flag_clr = '0;
		if (wr_en && apb_req.paddr == OFS_FLAGS)
			flag_clr = flags_t'(apb_req.pwdata[4:0]);
	end

	// write one to clear; a set in the same cycle wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			flags_reg <= '0;
		else if (ce)
			flags_reg <= (flags_reg & ~flag_clr) | flag_set;
	end

	assign flags = flags_reg;

	// output levels: a match on the rising slope or at bottom clears (non-inverted),
	// a match at top or on the falling slope sets, so the extreme values hold steady
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_level_reg <= '0;
		end else if (ce && timer_tick_enable && dual_mode) begin
			for (int i = 0; i < NCH; i++) begin
				if (count_value == compare_active_reg[i]) begin
					case (output_action_sel[i])
						ACT_NONINV: out_level_reg[i] <= at_top || (slope_reg == SLOPE_DOWN && !at_bottom);
						ACT_INV:    out_level_reg[i] <= !(at_top || (slope_reg == SLOPE_DOWN && !at_bottom));
						ACT_TOGGLE: begin
							if (i == 0 && waveform_mode_sel[3])
								out_level_reg[i] <= !out_level_reg[i];
						end
						default: begin
						end
					endcase
				end
			end
		end
	end

	// pin drive: connected action and direction bit both required
	always_comb begin
		for (int i = 0; i < NCH; i++) begin
			compare_output_oe[i] = pin_direction_bit[i] && (output_action_sel[i][1] ||
				(i == 0 && output_action_sel[i] == ACT_TOGGLE && waveform_mode_sel[3]));
			compare_output[i] = compare_output_oe[i] && out_level_reg[i];
		end
	end
endmodule
`default_nettype wire

//--- pwm_timer_checker.sv
// port checker for the dual-slope pwm timer, bound below the module
// assumes one pclk domain and zero-wait apb answers gated by ce
`timescale 1ns/1ps
`default_nettype none
module pwm_timer_checker
	import pwm_timer_pkg::*;
#(
	parameter int NCH = NUM_CH
)
(
	input wire logic           pclk,
	input wire logic           presetn,
	input wire logic           ce,
	input wire apb_req_t       apb_req,
	input wire logic [31:0]    prdata,
	input wire logic           pready,
	input wire logic           pslverr,
	input wire logic [NCH-1:0] compare_output,
	input wire logic [NCH-1:0] compare_output_oe,
	input wire flags_t         flags
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	logic rd_go;
	logic clr_go;
	assign rd_go  = apb_req.psel && !apb_req.penable && !apb_req.pwrite && ce;
	assign clr_go = apb_req.psel && apb_req.penable && apb_req.pwrite && ce && apb_req.paddr == OFS_FLAGS;
	sequence bad_setup;
		apb_req.psel && !apb_req.penable && ce && apb_req.paddr > OFS_STATUS;
	endsequence
	sequence access;
		apb_req.psel && apb_req.penable && pready;
	endsequence
	ready_tracks_ce_a:
		assert property (pready == ce) else $error("pready differs from ce");
	freeze_when_off_a:
		assert property (!ce |=> $stable(flags) && $stable(compare_output)) else $error("state moved with ce low");
	pin_gated_a:
		assert property ((compare_output & ~compare_output_oe) == '0) else $error("pin driven while not enabled");
	ovf_sticky_a:
		assert property ($fell(flags.overflow_flag) |-> $past(clr_go && apb_req.pwdata[FLAG_OVF]))
		else $error("overflow flag dropped without clear");
	cap_sticky_a:
		assert property ($fell(flags.capture_flag) |-> $past(clr_go && apb_req.pwdata[FLAG_CAP]))
		else $error("capture flag dropped without clear");
	cmp_sticky_a:
		assert property ($fell(flags.compare_match_flag[0]) |-> $past(clr_go && apb_req.pwdata[FLAG_CMP_LSB]))
		else $error("compare flag dropped without clear");
	unmapped_err_a:
		assert property (bad_setup ##1 access |-> pslverr) else $error("no error on unmapped access");
	unmapped_zero_a:
		assert property (bad_setup ##0 !apb_req.pwrite ##1 access |-> prdata == 32'h0) else $error("unmapped read not zero");
	err_in_access_a:
		assert property (pslverr |-> apb_req.psel && apb_req.penable) else $error("error outside access phase");
	rdata_hold_a:
		assert property (!rd_go |=> $stable(prdata)) else $error("read data moved without read setup");
endmodule
bind dual_slope_pwm_timer pwm_timer_checker #(.NCH(NCH)) u_pwm_timer_checker (
	.pclk(pclk), .presetn(presetn), .ce(ce), .apb_req(apb_req), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .compare_output(compare_output), .compare_output_oe(compare_output_oe), .flags(flags));
`default_nettype wire

//--- pwm_timer_pkg.sv
// constants, register map and carrier types for the dual-slope pwm timer
// assumes an apb master on pclk and a single synchronous clock domain
// Overview of operation
// - phase correct mode sets overflow flag on the tick where counter is at bottom.
// - phase correct with register top raises that source's flag when buffers load at top.
// - with a fixed top, compare writes clear bits above the active resolution.
// - phase correct loads buffered compares at top; top change may give asymmetric period.
// - output action two gives non-inverted pwm, three gives inverted pwm.
// - compare level reaches the pin only while its direction bit selects output.
// - non-inverting clears on up-count match, sets on down-count match; inverting opposite.
// - counter steps on prescaled tick of 1, 8, 64, 256 or 1024; period twice top.
// - compare at bottom holds output low, at top holds it high; inverted gives opposite.
// - phase-and-frequency correct is mode 8 (capture top) or mode 9 (channel a top).
// - counter runs 0x0000 up to top, holds top one tick, then down to bottom.
// - phase-and-frequency correct loads buffers at bottom with overflow flag in that tick.
// - phase-and-frequency correct with register top sets that source's flag at top.
// - a channel's compare flag sets on each dual-slope tick where counter equals its active compare value.
// - all logic on pclk; the prescaled tick only enables steps, flags, output levels and buffer loads.
// - phase correct is modes 1, 2, 3 (tops 0x00FF, 0x01FF, 0x03FF), 10 or 11.
package pwm_timer_pkg;
	localparam int          ADDR_W      = 8;
	localparam int          CNT_W       = 16;
	localparam int          NUM_CH      = 3;
	localparam logic [7:0]  OFS_CTRL    = 8'h00;
	localparam logic [7:0]  OFS_OUTCFG  = 8'h04;
	localparam logic [7:0]  OFS_COUNT   = 8'h08;
	localparam logic [7:0]  OFS_CMP_A   = 8'h0C;
	localparam logic [7:0]  OFS_CMP_B   = 8'h10;
	localparam logic [7:0]  OFS_CMP_C   = 8'h14;
	localparam logic [7:0]  OFS_CAPTOP  = 8'h18;
	localparam logic [7:0]  OFS_FLAGS   = 8'h1C;
	localparam logic [7:0]  OFS_STATUS  = 8'h20;
	localparam int          CTRL_MODE_LSB = 0;
	localparam int          CTRL_CS_LSB   = 4;
	localparam int          OUTCFG_DIR_LSB = 8;
	localparam int          FLAG_OVF    = 0;
	localparam int          FLAG_CMP_LSB = 1;
	localparam int          FLAG_CAP    = 4;
	localparam logic [15:0] BOTTOM      = 16'h0000;
	localparam logic [15:0] TOP_8BIT    = 16'h00FF;
	localparam logic [15:0] TOP_9BIT    = 16'h01FF;
	localparam logic [15:0] TOP_10BIT   = 16'h03FF;
	localparam logic [3:0]  MODE_PC8    = 4'h1;
	localparam logic [3:0]  MODE_PC9    = 4'h2;
	localparam logic [3:0]  MODE_PC10   = 4'h3;
	localparam logic [3:0]  MODE_PFC_CAP = 4'h8;
	localparam logic [3:0]  MODE_PFC_A  = 4'h9;
	localparam logic [3:0]  MODE_PC_CAP = 4'hA;
	localparam logic [3:0]  MODE_PC_A   = 4'hB;
	localparam logic [1:0]  ACT_OFF     = 2'h0;
	localparam logic [1:0]  ACT_TOGGLE  = 2'h1;
	localparam logic [1:0]  ACT_NONINV  = 2'h2;
	localparam logic [1:0]  ACT_INV     = 2'h3;
	localparam logic [2:0]  CS_STOP     = 3'h0;
	localparam logic [2:0]  CS_DIV1     = 3'h1;
	localparam logic [2:0]  CS_DIV8     = 3'h2;
	localparam logic [2:0]  CS_DIV64    = 3'h3;
	localparam logic [2:0]  CS_DIV256   = 3'h4;
	localparam logic [2:0]  CS_DIV1024  = 3'h5;
	localparam int          PRESC_W     = 10;
	localparam int          DIV8        = 8;
	localparam int          DIV64       = 64;
	localparam int          DIV256      = 256;
	localparam int          DIV1024     = 1024;

	typedef struct packed {
		logic              psel;
		logic              penable;
		logic              pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [31:0]       pwdata;
	} apb_req_t;

	typedef struct packed {
		logic              capture_flag;
		logic [NUM_CH-1:0] compare_match_flag;
		logic              overflow_flag;
	} flags_t;
endpackage

//--- tb_top.sv
// self-checking bench for the dual-slope pwm timer with a cycle model of counter, pins and flags
// assumes the prescaler ticks every ce cycle at divide-by-one
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import pwm_timer_pkg::*;
;
	logic        pclk = 0;
	logic        presetn = 0;
	logic        ce = 1;
	apb_req_t    req = '0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [2:0]  pin;
	logic [2:0]  pin_oe;
	flags_t      flags;
	logic [31:0] rdq[$];
	logic [31:0] cyc = 0;
	int          err_count = 0;
	int          check_count = 0;
	logic        run = 0;
	logic [3:0]  mode;
	logic [15:0] cnt;
	logic [15:0] captop;
	logic        up;
	logic [15:0] buff[3];
	logic [15:0] actv[3];
	logic [2:0]  lvl;
	flags_t      mf;
	logic        arm = 0;
	logic [1:0]  acta;
	localparam logic [2:0] INV = 3'b010;
	localparam logic [2:0] DIR = 3'b011;

	dual_slope_pwm_timer u_dual_slope_pwm_timer (.pclk(pclk), .presetn(presetn), .ce(ce), .apb_req(req),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .compare_output(pin),
		.compare_output_oe(pin_oe), .flags(flags));

	initial forever #10 pclk = ~pclk;
	always @(posedge pclk) cyc <= cyc + 1;

	task automatic test_done;
		if (err_count == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		req <= '{1'b1, 1'b0, w, a, d};
		@(posedge pclk);
		req.penable <= 1'b1;
		do begin
			@(posedge pclk);
			if (++n > 50) begin
				err_count++;
				test_done();
			end
		end while (pready !== 1'b1);
		req <= '0;
		// one idle edge, so a following call never drives req twice in one step
		@(posedge pclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		rdq.push_back(e);
		apb(1'b0, a, 32'h0);
	endtask
	// read results are judged where they appear, oldest note first
	always @(posedge pclk) if (req.psel && req.penable && !req.pwrite && pready === 1'b1) chk(prdata, rdq.pop_front());

	task automatic reset;
		presetn <= 1'b0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
	endtask
	task automatic wait_pin(input logic v);
		int n;
		n = 0;
		while (pin[0] !== v) begin
			@(posedge pclk);
			if (++n > 20000) begin
				err_count++;
				test_done();
			end
		end
	endtask
	task automatic period(input logic [3:0] m, input logic [2:0] cs, input logic [31:0] exp);
		logic [31:0] t0;
		reset();
		wr(OFS_CAPTOP, 32'h3);
		wr(OFS_CMP_A, 32'h1);
		wr(OFS_OUTCFG, {21'h0, 3'b001, 6'h0, ACT_NONINV});
		wr(OFS_CTRL, {25'h0, cs, m});
		wait_pin(1'b0);
		wait_pin(1'b1);
		t0 = cyc;
		wait_pin(1'b0);
		wait_pin(1'b1);
		chk(cyc - t0, exp);
	endtask

	// reference model, one step per tick at divide-by-one; it mirrors the bench's own
	// writes at the edge they land, so mid-run buffer and top changes stay in step
	always @(posedge pclk) begin
		logic [15:0] top;
		top = mode[0] ? actv[0] : captop;
		if (!presetn) begin
			run <= 1'b0;
			mode <= 4'h0;
			captop <= 16'h0;
			acta <= ACT_OFF;
			cnt <= 16'h0;
			up <= 1'b1;
			lvl <= 3'h0;
			mf <= '0;
			buff <= '{default: 16'h0};
			actv <= '{default: 16'h0};
		end else begin
			if (req.psel && req.penable && req.pwrite && pready === 1'b1) begin
				if (req.paddr == OFS_CTRL) run <= arm;
				if (req.paddr == OFS_CTRL) mode <= req.pwdata[3:0];
				if (req.paddr == OFS_OUTCFG) acta <= req.pwdata[1:0];
				if (req.paddr == OFS_CAPTOP) captop <= req.pwdata[15:0];
				for (int i = 0; i < 3; i++) if (req.paddr == OFS_CMP_A + 8'(4 * i)) buff[i] <= req.pwdata[15:0];
			end
			// while the model is not running the active compare follows its buffer
			if (!run) actv <= buff;
			if (run) begin
				if (cnt == 16'h0) mf.overflow_flag <= 1'b1;
				if (cnt == top && !mode[0]) mf.capture_flag <= 1'b1;
				for (int i = 0; i < 3; i++) if (cnt == actv[i]) begin
					mf.compare_match_flag[i] <= 1'b1;
					if (i == 0 && acta == ACT_TOGGLE)
						lvl[i] <= !lvl[i];
					else
						lvl[i] <= (cnt == top || (!up && cnt != 16'h0)) ^ INV[i];
				end
				if (cnt == (mode[1] ? top : 16'h0)) actv <= buff;
				if (up) begin
					cnt <= (cnt == top) ? cnt - 1 : cnt + 1;
					up <= (cnt != top);
				end else begin
					cnt <= (cnt == 16'h0) ? 16'h1 : cnt - 1;
					up <= (cnt == 16'h0);
				end
			end
		end
	end
	always @(negedge pclk) if (run) begin
		chk({29'h0, pin}, {29'h0, lvl & DIR});
		chk({29'h0, pin_oe}, {29'h0, DIR});
		chk({27'h0, flags}, {27'h0, mf});
	end

	task automatic pwm_run(input logic [3:0] m, input logic [1:0] act_a);
		logic [15:0] t;
		logic [15:0] v [3];
		reset();
		t = 16'd5 + 16'($urandom_range(3, 0));
		v[0] = m[0] ? t : 16'($urandom_range(t, 0));
		v[1] = m[1] ? 16'h0 : t;
		v[2] = 16'($urandom_range(t, 0));
		for (int i = 0; i < 3; i++) wr(OFS_CMP_A + 8'(4 * i), {16'h0, v[i]});
		wr(OFS_CAPTOP, {16'h0, t});
		// channel b inverted so the opposite polarity reaches a pin; c stays undriven
		wr(OFS_OUTCFG, {21'h0, DIR, 2'h0, ACT_NONINV, ACT_INV, act_a});
		arm = 1'b1;
		wr(OFS_CTRL, {25'h0, CS_DIV1, m});
		repeat (60) @(posedge pclk);
		// a raised top keeps every compare reachable
		if (m[0])
			wr(OFS_CMP_A, {16'h0, t + 16'd3});
		else
			wr(OFS_CAPTOP, {16'h0, t + 16'd3});
		repeat (80) @(posedge pclk);
		arm = 1'b0;
		wr(OFS_CTRL, {25'h0, CS_STOP, m});
		wr(OFS_FLAGS, 32'h1F);
		rd(OFS_FLAGS, 32'h0);
	endtask

	initial begin
		void'($urandom(32'hDE57));
		reset();
		rd(8'h40, 32'h0);
		wr(8'h44, 32'h5);
		ce <= 1'b0;
		fork
			begin
				repeat (4) @(posedge pclk);
				ce <= 1'b1;
			end
		join_none
		wr(OFS_CMP_A, 32'h7);
		rd(OFS_CMP_A, 32'h7);
		for (int m = 1; m <= 3; m++) begin
			reset();
			wr(OFS_CTRL, {25'h0, CS_STOP, 4'(m)});
			wr(OFS_CMP_B, 32'hFFFF);
			rd(OFS_CMP_B, {16'h0, m == 1 ? TOP_8BIT : m == 2 ? TOP_9BIT : TOP_10BIT});
			period(4'(m), CS_DIV1, m == 1 ? 2 * TOP_8BIT : m == 2 ? 2 * TOP_9BIT : 2 * TOP_10BIT);
		end
		period(MODE_PC_CAP, CS_DIV8, 6 * DIV8);
		period(MODE_PC_CAP, CS_DIV64, 6 * DIV64);
		period(MODE_PC_CAP, CS_DIV256, 6 * DIV256);
		period(MODE_PC_CAP, CS_DIV1024, 6 * DIV1024);
		pwm_run(MODE_PC_CAP, ACT_NONINV);
		pwm_run(MODE_PC_CAP, ACT_TOGGLE);
		pwm_run(MODE_PC_A, ACT_NONINV);
		pwm_run(MODE_PFC_CAP, ACT_NONINV);
		pwm_run(MODE_PFC_A, ACT_NONINV);
		test_done();
	end
endmodule
`default_nettype wire

//--- tick_prescaler.sv
// prescaler that turns pclk into a one-cycle timer tick enable
// assumes clock select is stable register state from the timer
`timescale 1ns/1ps
`default_nettype none
module tick_prescaler
	import pwm_timer_pkg::*;
(
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       ce,
	input  wire logic [2:0] clock_sel,
	output logic            timer_tick_enable
);
	logic [PRESC_W-1:0] div_reg;
	logic               hit;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_reg <= '0;
		end else if (ce) begin
			if (clock_sel == CS_STOP)
				div_reg <= '0;
			else
				div_reg <= div_reg + 1'b1;
		end
	end

	// free-running divider: first tick after a select change may come early
	always_comb begin
		case (clock_sel)
			CS_DIV1:    hit = 1'b1;
			CS_DIV8:    hit = (div_reg[2:0] == 3'(DIV8 - 1));
			CS_DIV64:   hit = (div_reg[5:0] == 6'(DIV64 - 1));
			CS_DIV256:  hit = (div_reg[7:0] == 8'(DIV256 - 1));
			CS_DIV1024: hit = (div_reg == PRESC_W'(DIV1024 - 1));
			default:    hit = 1'b0;
		endcase
	end

	assign timer_tick_enable = ce && hit;
endmodule
`default_nettype wire
